// >>> rtl/vsh_host_port.sv
/*
 * Host register port: asynchronous strobes, control registers and four
 * coefficient stores reached through auto-incrementing counters.
 * Assumes the host holds strobes several clocks and releases between accesses.
 */
`timescale 1ns/100ps
// ==========================================================
// Overview of operation
// - Four-bit address; coefficient stores via counters
// - Async strobes synchronised; host holds them long
// - Write to F clears all four counters
// - Each coefficient access advances its counter
// - Address 1 reaches 24-entry horizontal luma store
// - Address 2 reaches 16-entry horizontal chroma store
// - Address 5 reaches 70-entry vertical luma store
// - Address 6 reaches 140-entry vertical chroma store
// - Address 3 value 02 enables sync pin reset
// - Address 7 resets to 01; 21 loops back
// - Address A top six bits: line delay
// - Pixel delay: A bits 1:0 over B
// - Option bit 6 blanks with colour C,D,E
// - Mode, option, delay, colour changes take effect at field start
// - Mode bits 0-2: interpolate, 525-line, quarter
// - Mode bits 3,4 low remove video offsets
// - Mode bit5 lock; bits 6,7 edge polarity
// - Option bits 0-2: chroma order, field detect
// - Option bit3 DRAM size, bit4 split screen
// - Option bit5 ready flag, bit7 write inhibit
module vsh_host_port
    import vsh_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic [3:0]  host_addr,
    input  wire logic [7:0]  host_wdata,
    input  wire logic        host_rd,
    input  wire logic        host_wr,
    input  wire logic        host_en_b,
    input  wire logic        field_start,
    input  wire logic        frame_reset_pin,
    input  wire logic        vertical_reset_pin,
    output logic      [7:0]  host_rdata,
    output logic             host_rdata_oe,
    output vsh_mode_t        mode_out,
    output vsh_option_t      option_out,
    output vsh_colour_t      blank_colour,
    output logic             blank_active,
    output logic      [5:0]  line_delay,
    output logic      [9:0]  pixel_delay,
    output logic             loopback_on,
    output logic             sync_reset_req
);

    // ==========================================================
    // Strobe synchronisers
    logic [2:0] rd_sync_ff;
    logic [2:0] wr_sync_ff;
    logic [2:0] en_sync_ff;
    logic [2:0] fs_sync_ff;
    logic [2:0] fr_sync_ff;
    logic [2:0] vr_sync_ff;
    logic       rd_q_ff;
    logic       wr_q_ff;
    logic       en_q_ff;
    logic       fs_q_ff;
    logic       fr_q_ff;
    logic       vr_q_ff;

    // A level counts once the second and third stages agree
    function automatic logic filt(input logic [2:0] s, input logic old);
        filt = (s[1] == s[2]) ? s[2] : old;
    endfunction

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_sync_ff <= 3'h0;
            wr_sync_ff <= 3'h0;
            en_sync_ff <= 3'h7;
            fs_sync_ff <= 3'h0;
            fr_sync_ff <= 3'h0;
            vr_sync_ff <= 3'h0;
            rd_q_ff    <= 1'b0;
            wr_q_ff    <= 1'b0;
            en_q_ff    <= 1'b1;
            fs_q_ff    <= 1'b0;
            fr_q_ff    <= 1'b0;
            vr_q_ff    <= 1'b0;
        end
        else
        begin
            rd_sync_ff <= {rd_sync_ff[1:0], host_rd};
            wr_sync_ff <= {wr_sync_ff[1:0], host_wr};
            en_sync_ff <= {en_sync_ff[1:0], host_en_b};
            fs_sync_ff <= {fs_sync_ff[1:0], field_start};
            fr_sync_ff <= {fr_sync_ff[1:0], frame_reset_pin};
            vr_sync_ff <= {vr_sync_ff[1:0], vertical_reset_pin};
            rd_q_ff    <= filt(rd_sync_ff, rd_q_ff);
            wr_q_ff    <= filt(wr_sync_ff, wr_q_ff);
            en_q_ff    <= filt(en_sync_ff, en_q_ff);
            fs_q_ff    <= filt(fs_sync_ff, fs_q_ff);
            fr_q_ff    <= filt(fr_sync_ff, fr_q_ff);
            vr_q_ff    <= filt(vr_sync_ff, vr_q_ff);
        end
    end

    // ==========================================================
    // Access sequencer: one action per held strobe
    vsh_state_t state_ff;
    vsh_state_t nxt_state;
    logic       act_is_wr_ff;
    logic       strobe_on;
    logic       fs_d_ff;
    logic       field_go;

    assign strobe_on = !en_q_ff && (rd_q_ff || wr_q_ff);

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: if (strobe_on) nxt_state = ST_ACT;
            ST_ACT:  nxt_state = ST_WAIT;
            ST_WAIT: if (!strobe_on) nxt_state = ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_ff     <= ST_IDLE;
            act_is_wr_ff <= 1'b0;
            fs_d_ff      <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            fs_d_ff  <= fs_q_ff;
            if (state_ff == ST_IDLE && strobe_on)
                act_is_wr_ff <= wr_q_ff;
        end
    end

    assign field_go = fs_q_ff && !fs_d_ff;

    logic do_wr;
    logic do_rd;
    assign do_wr = (state_ff == ST_ACT) && act_is_wr_ff;
    assign do_rd = (state_ff == ST_ACT) && !act_is_wr_ff;

    // ==========================================================
    // Coefficient stores and counters
    logic [7:0]       hl_mem [HLUMA_DEPTH];
    logic [7:0]       hc_mem [HCHROMA_DEPTH];
    logic [7:0]       vl_mem [VLUMA_DEPTH];
    logic [7:0]       vc_mem [VCHROMA_DEPTH];
    logic [CNT_W-1:0] hl_cnt_ff;
    logic [CNT_W-1:0] hc_cnt_ff;
    logic [CNT_W-1:0] vl_cnt_ff;
    logic [CNT_W-1:0] vc_cnt_ff;
    logic             do_acc;
    logic             clr_cnt;

    assign do_acc  = do_rd || do_wr;
    assign clr_cnt = do_wr && host_addr == OFS_CNT_CLEAR;

    // Counter past the store depth is undefined; wrap keeps it in range
    function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] c, input int d);
        bump = (c == CNT_W'(d - 1)) ? '0 : c + 1'b1;
    endfunction

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hl_cnt_ff <= '0;
            hc_cnt_ff <= '0;
            vl_cnt_ff <= '0;
            vc_cnt_ff <= '0;
        end
        else if (clr_cnt)
        begin
            hl_cnt_ff <= '0;
            hc_cnt_ff <= '0;
            vl_cnt_ff <= '0;
            vc_cnt_ff <= '0;
        end
        else if (do_acc)
        begin
            case (host_addr)
                OFS_HLUMA:   hl_cnt_ff <= bump(hl_cnt_ff, HLUMA_DEPTH);
                OFS_HCHROMA: hc_cnt_ff <= bump(hc_cnt_ff, HCHROMA_DEPTH);
                OFS_VLUMA:   vl_cnt_ff <= bump(vl_cnt_ff, VLUMA_DEPTH);
                OFS_VCHROMA: vc_cnt_ff <= bump(vc_cnt_ff, VCHROMA_DEPTH);
                default:     ;
            endcase
        end
    end

    // Stores have no reset: contents are loaded by the host
    always_ff @(posedge clock)
    begin
        if (do_wr && host_addr == OFS_HLUMA)
            hl_mem[hl_cnt_ff[4:0]] <= host_wdata;
        if (do_wr && host_addr == OFS_HCHROMA)
            hc_mem[hc_cnt_ff[3:0]] <= host_wdata;
        if (do_wr && host_addr == OFS_VLUMA)
            vl_mem[vl_cnt_ff[6:0]] <= host_wdata;
        if (do_wr && host_addr == OFS_VCHROMA)
            vc_mem[vc_cnt_ff] <= host_wdata;
    end

    // ==========================================================
    // Control registers
    logic [7:0]  sync_rst_ff;
    logic [7:0]  loopback_ff;
    logic [7:0]  mode_ff;
    logic [7:0]  option_ff;
    logic [7:0]  dly_high_ff;
    logic [7:0]  pix_low_ff;
    vsh_colour_t colour_ff;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sync_rst_ff <= RST_REG;
            loopback_ff <= RST_LOOPBACK;
            mode_ff     <= RST_REG;
            option_ff   <= RST_REG;
            dly_high_ff <= RST_REG;
            pix_low_ff  <= RST_REG;
            colour_ff   <= {3{RST_REG}};
        end
        else if (do_wr)
        begin
            case (host_addr)
                OFS_SYNC_RST: sync_rst_ff <= host_wdata;
                OFS_LOOPBACK: loopback_ff <= host_wdata;
                OFS_MODE:     mode_ff     <= host_wdata;
                OFS_OPTION:   option_ff   <= host_wdata;
                OFS_DLY_HIGH: dly_high_ff <= host_wdata;
                OFS_PIX_LOW:  pix_low_ff  <= host_wdata;
                OFS_BLANK_Y:  colour_ff.y <= host_wdata;
                OFS_BLANK_U:  colour_ff.u <= host_wdata;
                OFS_BLANK_V:  colour_ff.v <= host_wdata;
                default:      ;
            endcase
        end
    end

    // ==========================================================
    // Field-aligned outputs; pending values apply at the field start. Loopback and sync reset follow their registers every clock
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mode_out     <= vsh_mode_t'(RST_REG);
            option_out   <= vsh_option_t'(RST_REG);
            blank_colour <= {3{RST_REG}};
            blank_active <= 1'b0;
            line_delay   <= 6'h00;
            pixel_delay  <= 10'h000;
        end
        else if (field_go)
        begin
            mode_out     <= vsh_mode_t'(mode_ff);
            option_out   <= vsh_option_t'(option_ff);
            blank_colour <= colour_ff;
            blank_active <= option_ff[OPT_BLANK_BIT];
            line_delay   <= dly_high_ff[7:DLY_LINE_LSB];
            pixel_delay  <= {dly_high_ff[PIX_MSB_BIT:0], pix_low_ff};
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            loopback_on    <= 1'b0;
            sync_reset_req <= 1'b0;
        end
        else
        begin
            loopback_on    <= (loopback_ff == LOOPBACK_TEST);
            sync_reset_req <= (sync_rst_ff == SYNC_RST_ON) && (fr_q_ff || vr_q_ff);
        end
    end

    // ==========================================================
    // Read data, captured in the action cycle and held through the strobe
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            host_rdata    <= 8'h00;
            host_rdata_oe <= 1'b0;
        end
        else
        begin
            host_rdata_oe <= (nxt_state != ST_IDLE) && !act_is_wr_ff && rd_q_ff
                             && state_ff != ST_IDLE;
            if (do_rd)
            begin
                case (host_addr)
                    OFS_HLUMA:    host_rdata <= hl_mem[hl_cnt_ff[4:0]];
                    OFS_HCHROMA:  host_rdata <= hc_mem[hc_cnt_ff[3:0]];
                    OFS_VLUMA:    host_rdata <= vl_mem[vl_cnt_ff[6:0]];
                    OFS_VCHROMA:  host_rdata <= vc_mem[vc_cnt_ff];
                    OFS_SYNC_RST: host_rdata <= sync_rst_ff;
                    OFS_LOOPBACK: host_rdata <= loopback_ff;
                    OFS_MODE:     host_rdata <= mode_ff;
                    OFS_OPTION:   host_rdata <= option_ff;
                    OFS_DLY_HIGH: host_rdata <= dly_high_ff;
                    OFS_PIX_LOW:  host_rdata <= pix_low_ff;
                    OFS_BLANK_Y:  host_rdata <= colour_ff.y;
                    OFS_BLANK_U:  host_rdata <= colour_ff.u;
                    OFS_BLANK_V:  host_rdata <= colour_ff.v;
                    default:      host_rdata <= 8'h00;
                endcase
            end
        end
    end

    // ==========================================================
    // Checks
    property p_clear_all;
        @(posedge clock) disable iff (!rst_b)
        clr_cnt |=> (hl_cnt_ff == 0 && hc_cnt_ff == 0 && vl_cnt_ff == 0 && vc_cnt_ff == 0);
    endproperty
    a_clear_all: assert property (p_clear_all) else $error("counters not cleared");

    property p_hl_step;
        @(posedge clock) disable iff (!rst_b)
        (do_acc && host_addr == OFS_HLUMA && hl_cnt_ff < CNT_W'(HLUMA_DEPTH - 1))
        |=> hl_cnt_ff == $past(hl_cnt_ff) + 1'b1;
    endproperty
    a_hl_step: assert property (p_hl_step) else $error("luma counter did not step");

    property p_one_action;
        @(posedge clock) disable iff (!rst_b)
        (state_ff == ST_ACT) |=> !(state_ff == ST_ACT);
    endproperty
    a_one_action: assert property (p_one_action) else $error("double action");

    property p_strobe_delay;
        @(posedge clock) disable iff (!rst_b)
        $rose(state_ff == ST_ACT) |-> $past(strobe_on);
    endproperty
    a_strobe_delay: assert property (p_strobe_delay) else $error("action w/o strobe");

    property p_loop_val;
        @(posedge clock) disable iff (!rst_b)
        (do_wr && host_addr == OFS_LOOPBACK && host_wdata == LOOPBACK_TEST) |=> ##1 loopback_on;
    endproperty
    a_loop_val: assert property (p_loop_val) else $error("loopback not set");

    property p_field_hold;
        @(posedge clock) disable iff (!rst_b)
        !field_go |=> $stable(mode_out) && $stable(option_out);
    endproperty
    a_field_hold: assert property (p_field_hold) else $error("control changed mid-field");

    property p_pixel;
        @(posedge clock) disable iff (!rst_b)
        field_go |=> pixel_delay == {$past(dly_high_ff[1:0]), $past(pix_low_ff)};
    endproperty
    a_pixel: assert property (p_pixel) else $error("pixel delay wrong");

    property p_blank;
        @(posedge clock) disable iff (!rst_b)
        field_go |=> blank_active == $past(option_ff[6]);
    endproperty
    a_blank: assert property (p_blank) else $error("blank flag wrong");

endmodule

// >>> rtl/vsh_pkg.sv
/*
 * Constants and carrier types for the video scaler host register port.
 * Assumes an 8-bit asynchronous host bus with a 4-bit address.
 */
package vsh_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [3:0] OFS_RSVD0      = 4'h0;
    localparam logic [3:0] OFS_HLUMA      = 4'h1;
    localparam logic [3:0] OFS_HCHROMA    = 4'h2;
    localparam logic [3:0] OFS_SYNC_RST   = 4'h3;
    localparam logic [3:0] OFS_RSVD4      = 4'h4;
    localparam logic [3:0] OFS_VLUMA      = 4'h5;
    localparam logic [3:0] OFS_VCHROMA    = 4'h6;
    localparam logic [3:0] OFS_LOOPBACK   = 4'h7;
    localparam logic [3:0] OFS_MODE       = 4'h8;
    localparam logic [3:0] OFS_OPTION     = 4'h9;
    localparam logic [3:0] OFS_DLY_HIGH   = 4'ha;
    localparam logic [3:0] OFS_PIX_LOW    = 4'hb;
    localparam logic [3:0] OFS_BLANK_Y    = 4'hc;
    localparam logic [3:0] OFS_BLANK_U    = 4'hd;
    localparam logic [3:0] OFS_BLANK_V    = 4'he;
    localparam logic [3:0] OFS_CNT_CLEAR  = 4'hf;

    // ==========================================================
    // Reset values and special codes
    localparam logic [7:0] RST_REG        = 8'h00;
    localparam logic [7:0] RST_LOOPBACK   = 8'h01;
    localparam logic [7:0] LOOPBACK_TEST  = 8'h21;
    localparam logic [7:0] SYNC_RST_ON    = 8'h02;

    // ==========================================================
    // Coefficient store depths
    localparam int HLUMA_DEPTH   = 24;
    localparam int HCHROMA_DEPTH = 16;
    localparam int VLUMA_DEPTH   = 70;
    localparam int VCHROMA_DEPTH = 140;
    localparam int CNT_W         = 8;

    // ==========================================================
    // Field positions
    localparam int DLY_LINE_LSB  = 2;
    localparam int PIX_MSB_BIT   = 1;
    localparam int OPT_BLANK_BIT = 6;

    // ==========================================================
    // Timing: strobe must stand this long before it is acted on
    localparam int CLK_PERIOD_NS = 50;
    localparam int STROBE_MIN_NS = 50;
    localparam int STROBE_CYC    = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // Carrier types
    typedef struct packed {
        logic nsc_pol_h;   // bit7 horizontal edge
        logic ver_pol;     // bit6 vertical edge
        logic ext_lock;    // bit5
        logic chroma_raw;  // bit4
        logic luma_raw;    // bit3
        logic quarter;     // bit2
        logic std_525;     // bit1
        logic interp;      // bit0
    } vsh_mode_t;

    typedef struct packed {
        logic dram_wr_off; // bit7
        logic blank;       // bit6
        logic ready_off;   // bit5
        logic split;       // bit4
        logic word_256k;   // bit3
        logic field_sel;   // bit2
        logic ext_field;   // bit1
        logic v_first;     // bit0
    } vsh_option_t;

    typedef struct packed {
        logic [7:0] y;
        logic [7:0] u;
        logic [7:0] v;
    } vsh_colour_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ACT  = 3'b010,
        ST_WAIT = 3'b100
    } vsh_state_t;

endpackage

// >>> test/vsh_host_model.sv
/*
 * Host processor model for the video scaler register port: drives the
 * asynchronous strobes, address and write data, and collects read data.
 * Assumes one clock and that callers run its tasks one at a time.
 */
`timescale 1ns/100ps
module vsh_host_model
(
    input  wire logic       clock,
    input  wire logic [7:0] host_rdata,
    input  wire logic       host_rdata_oe,
    output logic      [3:0] host_addr,
    output logic      [7:0] host_wdata,
    output logic            host_rd,
    output logic            host_wr,
    output logic            host_en_b
);
    // ==========================================================
    // Idle bus
    initial
    begin
        host_addr  = 4'h0;
        host_wdata = 8'h00;
        host_rd    = 1'b0;
        host_wr    = 1'b0;
        host_en_b  = 1'b1;
    end

    // ==========================================================
    // Accesses
    // Write strobes stand ten clocks, well past the sync pipeline; release gap six
    task automatic host_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        host_addr  <= a;
        host_wdata <= d;
        host_wr    <= 1'b1;
        host_en_b  <= 1'b0;
        repeat (10) @(posedge clock);
        host_wr    <= 1'b0;
        host_en_b  <= 1'b1;
        host_wdata <= ~d; // Released data must not look valid
        repeat (6) @(posedge clock);
    endtask

    // Waits for the device to drive the bus, bounded so a dead port shows as X
    // Data is taken at the rising edge that shows the enable, then released
    task automatic host_read(input logic [3:0] a, output logic [7:0] d);
        int n;
        d = 8'hxx;
        @(posedge clock);
        host_addr <= a;
        host_rd   <= 1'b1;
        host_en_b <= 1'b0;
        for (n = 0; n < 20; n++)
        begin
            @(posedge clock);
            if (host_rdata_oe === 1'b1)
            begin
                d = host_rdata;
                break;
            end
        end
        host_rd   <= 1'b0;
        host_en_b <= 1'b1;
        repeat (6) @(posedge clock);
    endtask
endmodule

// >>> test/vsh_host_port_tb.sv
/*
 * Self-checking bench for the host register port: registers, deferred
 * control outputs, special codes and the four coefficient stores.
 * Assumes the host model above and a 50 ns clock.
 */
`timescale 1ns/100ps
module vsh_host_port_tb;
    import vsh_pkg::*;

    logic        clock;
    logic        rst_b;
    logic [3:0]  host_addr;
    logic [7:0]  host_wdata;
    logic        host_rd;
    logic        host_wr;
    logic        host_en_b;
    logic        field_start;
    logic        frame_reset_pin;
    logic        vertical_reset_pin;
    logic [7:0]  host_rdata;
    logic        host_rdata_oe;
    vsh_mode_t   mode_out;
    vsh_option_t option_out;
    vsh_colour_t blank_colour;
    logic        blank_active;
    logic [5:0]  line_delay;
    logic [9:0]  pixel_delay;
    logic        loopback_on;
    logic        sync_reset_req;
    int          fails;
    int          tests_run;
    int          cycles;
    logic [7:0]  rd;

    vsh_host_port i_dut (.clock(clock), .rst_b(rst_b), .host_addr(host_addr),
        .host_wdata(host_wdata), .host_rd(host_rd), .host_wr(host_wr),
        .host_en_b(host_en_b), .field_start(field_start),
        .frame_reset_pin(frame_reset_pin), .vertical_reset_pin(vertical_reset_pin),
        .host_rdata(host_rdata), .host_rdata_oe(host_rdata_oe), .mode_out(mode_out),
        .option_out(option_out), .blank_colour(blank_colour),
        .blank_active(blank_active), .line_delay(line_delay),
        .pixel_delay(pixel_delay), .loopback_on(loopback_on),
        .sync_reset_req(sync_reset_req));

    vsh_host_model i_host (.clock(clock), .host_rdata(host_rdata),
        .host_rdata_oe(host_rdata_oe), .host_addr(host_addr),
        .host_wdata(host_wdata), .host_rd(host_rd), .host_wr(host_wr),
        .host_en_b(host_en_b));

    // ==========================================================
    // Clock, reset, timeout
    always #25 clock = ~clock;

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            fails++;
            stop_test();
        end
    end

    // ==========================================================
    // Helpers
    task automatic check(input string what, input logic [23:0] seen,
                         input logic [23:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("Counts: %0d compared, %0d failed", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Field start is asynchronous; hold it past the sync pipeline
    task automatic new_field();
        @(posedge clock);
        field_start <= 1'b1;
        repeat (6) @(posedge clock);
        field_start <= 1'b0;
        repeat (6) @(posedge clock);
    endtask

    function automatic logic [7:0] coef(input logic [3:0] a, input int i);
        return 8'(i * 5 + a * 16 + 3);
    endfunction

    // ==========================================================
    // Tests
    logic [3:0] rega [7] = '{4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he};
    logic [7:0] regv [7] = '{8'hd3, 8'h6c, 8'hb7, 8'h4e, 8'h81, 8'h2f, 8'hf0};
    logic [3:0] sta  [4] = '{4'h1, 4'h2, 4'h5, 4'h6};
    int         sdep [4] = '{HLUMA_DEPTH, HCHROMA_DEPTH, VLUMA_DEPTH, VCHROMA_DEPTH};

    initial
    begin
        clock = 1'b0;
        rst_b = 1'b0;
        field_start = 1'b0;
        frame_reset_pin = 1'b0;
        vertical_reset_pin = 1'b0;
        fails = 0;
        tests_run = 0;
        cycles = 0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        repeat (2) @(posedge clock);

        i_host.host_read(OFS_LOOPBACK, rd);
        check("reset loopback", 24'(rd), 24'(RST_LOOPBACK));
        i_host.host_read(OFS_SYNC_RST, rd);
        check("reset sync", 24'(rd), 24'h0);
        for (int k = 0; k < 7; k++)
        begin
            i_host.host_read(rega[k], rd);
            check("reset reg", 24'(rd), 24'h0);
        end
        $display("Test reset values done");

        for (int k = 0; k < 7; k++)
            i_host.host_write(rega[k], regv[k]);
        for (int k = 0; k < 7; k++)
        begin
            i_host.host_read(rega[k], rd);
            check("reg readback", 24'(rd), 24'(regv[k]));
        end
        i_host.host_write(OFS_RSVD0, 8'hff);
        i_host.host_write(OFS_RSVD4, 8'hff);
        i_host.host_read(OFS_RSVD0, rd);
        check("reserved 0", 24'(rd), 24'h0);
        i_host.host_read(OFS_RSVD4, rd);
        check("reserved 4", 24'(rd), 24'h0);
        $display("Test register access done");

        check("mode before field", 24'(mode_out), 24'h0);
        check("blank before field", 24'(blank_active), 24'h0);
        new_field();
        check("mode", 24'(mode_out), 24'hd3);
        check("option", 24'(option_out), 24'h6c);
        check("blank on", 24'(blank_active), 24'h1);
        check("colour", 24'(blank_colour), 24'h812ff0);
        check("line delay", 24'(line_delay), 24'h2d);
        check("pixel delay", 24'(pixel_delay), 24'h34e);
        i_host.host_write(OFS_OPTION, 8'h2c);
        check("blank held", 24'(blank_active), 24'h1);
        new_field();
        check("blank off", 24'(blank_active), 24'h0);
        $display("Test field controls done");

        i_host.host_write(OFS_LOOPBACK, LOOPBACK_TEST);
        check("loopback on", 24'(loopback_on), 24'h1);
        i_host.host_write(OFS_LOOPBACK, RST_LOOPBACK);
        check("loopback off", 24'(loopback_on), 24'h0);
        @(posedge clock);
        vertical_reset_pin <= 1'b1;
        repeat (8) @(posedge clock);
        check("sync gated", 24'(sync_reset_req), 24'h0);
        i_host.host_write(OFS_SYNC_RST, SYNC_RST_ON);
        check("sync vertical", 24'(sync_reset_req), 24'h1);
        vertical_reset_pin <= 1'b0;
        frame_reset_pin <= 1'b1;
        repeat (8) @(posedge clock);
        check("sync frame", 24'(sync_reset_req), 24'h1);
        i_host.host_write(OFS_SYNC_RST, RST_REG);
        check("sync off", 24'(sync_reset_req), 24'h0);
        frame_reset_pin <= 1'b0;
        $display("Test special codes done");

        // Loads run from index zero in order, padding included
        i_host.host_write(OFS_CNT_CLEAR, 8'h00);
        for (int s = 0; s < 4; s++)
            for (int i = 0; i < sdep[s]; i++)
                i_host.host_write(sta[s], coef(sta[s], i));
        i_host.host_read(OFS_CNT_CLEAR, rd);
        check("clear reads zero", 24'(rd), 24'h0);
        i_host.host_write(OFS_CNT_CLEAR, 8'h00);
        // Step every counter off zero so the clear below has work to do
        for (int s = 0; s < 4; s++)
            for (int i = 0; i < 2; i++)
            begin
                i_host.host_read(sta[s], rd);
                check("coefficient head", 24'(rd), 24'(coef(sta[s], i)));
            end
        i_host.host_write(OFS_CNT_CLEAR, 8'h00);
        for (int s = 0; s < 4; s++)
            for (int i = 0; i < sdep[s]; i++)
            begin
                i_host.host_read(sta[s], rd);
                check("coefficient", 24'(rd), 24'(coef(sta[s], i)));
            end
        $display("Test coefficient stores done");
        stop_test();
    end
endmodule
